/* File: verilog/occs_output_select.sv */
/*
  Output clock source select: byte registers that pick the source of
  the fifth, sixth and seventh output clocks, gate the two frame sync
  pins and set the secondary and primary synthesis frequencies.
  Assumes source clocks arrive asynchronously and are far slower than
  i_clock in simulation; the alternate-decode bits come from logic on
  i_clock. Register reads answer one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "occs_defines.svh"

module occs_output_select
  import occs_pkg::*;
#(
  parameter logic [15:0] P_FRAME_HALF_CYCLES =
    16'(`OCCS_CLOCK_HZ / (2 * `OCCS_FRAME_SYNC_HZ))
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wr_data,
  output logic [7:0] o_reg_rd_data,
  input wire logic i_out5_alt_decode,
  input wire logic i_out6_alt_decode,
  input wire logic i_out7_alt_decode,
  input wire logic i_primary_analog_loop,
  input wire logic i_secondary_analog_loop,
  input wire logic i_second_primary_analog_loop,
  input wire logic i_digital_rate_one,
  input wire logic i_digital_rate_two,
  input wire logic i_secondary_ref_div,
  input wire logic i_primary_ref_div,
  output logic o_out5_pin,
  output logic o_out6_pin,
  output logic o_out7_pin,
  output logic o_multiframe_sync_pin,
  output logic o_frame_sync_pin,
  output logic [19:0] o_primary_synth_freq_khz,
  output logic [19:0] o_primary_loop_freq_khz,
  output logic [19:0] o_secondary_synth_freq_khz,
  output logic [19:0] o_secondary_loop_freq_khz,
  output logic o_secondary_loop_enable,
  output logic o_secondary_synth_from_primary,
  output logic o_secondary_phase_measure
);

  localparam int unsigned NUM_DIV = 18;
  localparam int unsigned FRAMES_PER_MFRAME = `OCCS_FRAME_SYNC_HZ / `OCCS_MFRAME_SYNC_HZ;
  localparam logic [1:0] MFRAME_LAST = 2'(FRAMES_PER_MFRAME - 1);

  // Divider table: factor, origin loop (0 primary, 1 secondary, 2 second
  // primary) and the source slot it feeds
  localparam int unsigned DIV_FACTOR [NUM_DIV] = '{
    2, 4, 6, 8, 12, 16, 48, 2, 4, 5, 8, 10, 16, 48, 64, 2, 5, 10};
  localparam int unsigned DIV_ORIGIN [NUM_DIV] = '{
    0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2};
  localparam occs_src_t DIV_DEST [NUM_DIV] = '{
    OCCS_SRC_P2, OCCS_SRC_P4, OCCS_SRC_P6, OCCS_SRC_P8, OCCS_SRC_P12,
    OCCS_SRC_P16, OCCS_SRC_P48, OCCS_SRC_S2, OCCS_SRC_S4, OCCS_SRC_S5,
    OCCS_SRC_S8, OCCS_SRC_S10, OCCS_SRC_S16, OCCS_SRC_S48, OCCS_SRC_S64,
    OCCS_SRC_Q2, OCCS_SRC_Q5, OCCS_SRC_Q10};

  logic [7:0] output_select_five_six;
  logic [7:0] output_select_seven_sync;
  logic [7:0] secondary_loop_config;
  logic [7:0] primary_loop_config;

  logic [6:0] pin_raw;
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic [2:0] origin_clk;
  logic [2:0] origin_en;
  logic [NUM_DIV-1:0] div_out;
  logic [OCCS_NUM_SRC-1:0] src_vec;

  logic [15:0] frame_cnt;
  logic [1:0] mframe_cnt;
  logic wave_8k;
  logic wave_2k;
  logic mframe_gate;
  logic frame_gate;

  logic [3:0] sel_code [3];
  logic [2:0] alt_bit;
  occs_src_t sel_src [3];
  logic [2:0] pin_out;

  logic [3:0] secondary_synth_freq;
  logic [2:0] primary_to_secondary_freq;
  logic [2:0] primary_synth_freq;
  logic secondary_synth_from_primary;
  logic secondary_phase_measure;
  logic [19:0] next_secondary_khz;
  logic [19:0] next_primary_khz;
  logic secondary_loop_en;

  // Decoders

  function automatic occs_src_t decode_std(input occs_out_t which, input logic [3:0] code);
    occs_src_t r;
    r = OCCS_SRC_LOW;
    unique case (code)
      4'h0: r = OCCS_SRC_LOW;
      4'h1: r = OCCS_SRC_2K;
      4'h2: r = OCCS_SRC_8K;
      4'h3: r = (which == OCCS_OUT6) ? OCCS_SRC_P2 : OCCS_SRC_DIG2;
      4'h4: r = (which == OCCS_OUT7) ? OCCS_SRC_P2 : OCCS_SRC_DIG1;
      4'h5: r = (which == OCCS_OUT6) ? OCCS_SRC_P1 : OCCS_SRC_P48;
      4'h6: r = OCCS_SRC_P16;
      4'h7: r = OCCS_SRC_P12;
      4'h8: r = OCCS_SRC_P8;
      4'h9: r = OCCS_SRC_P6;
      4'ha: r = OCCS_SRC_P4;
      4'hb: r = (which == OCCS_OUT5) ? OCCS_SRC_S2 : OCCS_SRC_S64;
      4'hc: r = OCCS_SRC_S48;
      4'hd: r = OCCS_SRC_S16;
      4'he: r = OCCS_SRC_S8;
      4'hf: r = OCCS_SRC_S4;
    endcase
    return r;
  endfunction : decode_std

  // Undefined alternate codes park the pin low
  function automatic occs_src_t decode_alt(input occs_out_t which, input logic [3:0] code);
    occs_src_t r;
    logic fifth;
    r = OCCS_SRC_LOW;
    fifth = (which == OCCS_OUT5);
    case (code)
      4'h0: r = OCCS_SRC_LOW;
      4'h1: r = fifth ? OCCS_SRC_P2 : OCCS_SRC_S5;
      4'h2: r = fifth ? OCCS_SRC_P1 : OCCS_SRC_S2;
      4'h3: r = fifth ? OCCS_SRC_S10 : OCCS_SRC_S1;
      4'h4: r = fifth ? OCCS_SRC_Q10 : OCCS_SRC_Q5;
      4'h5: r = OCCS_SRC_Q2;
      4'h6: r = OCCS_SRC_Q1;
      4'h7: r = OCCS_SRC_SREF;
      4'h8: r = OCCS_SRC_PREF;
      default: r = OCCS_SRC_LOW;
    endcase
    return r;
  endfunction : decode_alt

  function automatic logic [19:0] secondary_table(input logic [3:0] code);
    logic [19:0] f;
    f = `OCCS_KHZ_OFF;
    case (code)
      4'h1: f = `OCCS_KHZ_77M760;
      4'h2: f = `OCCS_KHZ_24M576;
      4'h3: f = `OCCS_KHZ_32M768;
      4'h4: f = `OCCS_KHZ_37M056;
      4'h5: f = `OCCS_KHZ_24M704;
      4'h6: f = `OCCS_KHZ_68M736;
      4'h7: f = `OCCS_KHZ_44M736;
      4'h8: f = `OCCS_KHZ_25M248;
      4'h9: f = `OCCS_KHZ_62M500;
      4'ha: f = `OCCS_KHZ_30M720;
      4'hb: f = `OCCS_KHZ_40M000;
      4'hc: f = `OCCS_KHZ_26M000;
      default: f = `OCCS_KHZ_OFF;
    endcase
    return f;
  endfunction : secondary_table

  function automatic logic [19:0] p2s_table(input logic [2:0] code);
    logic [19:0] f;
    f = `OCCS_KHZ_OFF;
    case (code)
      3'h0: f = `OCCS_KHZ_24M576;
      3'h1: f = `OCCS_KHZ_62M500;
      3'h2: f = `OCCS_KHZ_32M768;
      3'h4: f = `OCCS_KHZ_37M056;
      3'h6: f = `OCCS_KHZ_24M704;
      3'h7: f = `OCCS_KHZ_25M248;
      default: f = `OCCS_KHZ_OFF;
    endcase
    return f;
  endfunction : p2s_table

  function automatic logic [19:0] primary_table(input logic [2:0] code);
    logic [19:0] f;
    f = `OCCS_KHZ_OFF;
    unique case (code)
      3'h0: f = `OCCS_KHZ_77M760;
      3'h1: f = `OCCS_KHZ_77M760;
      3'h2: f = `OCCS_KHZ_24M576;
      3'h3: f = `OCCS_KHZ_32M768;
      3'h4: f = `OCCS_KHZ_37M056;
      3'h5: f = `OCCS_KHZ_24M704;
      3'h6: f = `OCCS_KHZ_25M248;
      3'h7: f = `OCCS_KHZ_62M500;
    endcase
    return f;
  endfunction : primary_table

  // Register file

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      output_select_five_six <= `OCCS_RST_OUT_SEL_56;
    end else if (i_reg_wr_en && i_reg_addr == `OCCS_ADDR_OUT_SEL_56) begin
      output_select_five_six <= i_reg_wr_data & `OCCS_MASK_OUT_SEL_56;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      output_select_seven_sync <= `OCCS_RST_OUT_SEL_7_SYNC;
    end else if (i_reg_wr_en && i_reg_addr == `OCCS_ADDR_OUT_SEL_7_SYNC) begin
      output_select_seven_sync <= i_reg_wr_data & `OCCS_MASK_OUT_SEL_7_SYNC;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      secondary_loop_config <= `OCCS_RST_SEC_LOOP_CFG;
    end else if (i_reg_wr_en && i_reg_addr == `OCCS_ADDR_SEC_LOOP_CFG) begin
      secondary_loop_config <= i_reg_wr_data & `OCCS_MASK_SEC_LOOP_CFG;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      primary_loop_config <= `OCCS_RST_PRI_LOOP_CFG;
    end else if (i_reg_wr_en && i_reg_addr == `OCCS_ADDR_PRI_LOOP_CFG) begin
      primary_loop_config <= i_reg_wr_data & `OCCS_MASK_PRI_LOOP_CFG;
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rd_data <= 8'h00;
    end else if (i_reg_rd_en) begin
      case (i_reg_addr)
        `OCCS_ADDR_OUT_SEL_56: o_reg_rd_data <= output_select_five_six;
        `OCCS_ADDR_OUT_SEL_7_SYNC: o_reg_rd_data <= output_select_seven_sync;
        `OCCS_ADDR_SEC_LOOP_CFG: o_reg_rd_data <= secondary_loop_config;
        `OCCS_ADDR_PRI_LOOP_CFG: o_reg_rd_data <= primary_loop_config;
        default: o_reg_rd_data <= 8'h00;
      endcase
    end
  end

  // Loop frequency and mode settings

  assign secondary_synth_freq = secondary_loop_config[`OCCS_SEC_FREQ_MSB:`OCCS_SEC_FREQ_LSB];
  assign primary_to_secondary_freq =
    primary_loop_config[`OCCS_P2S_FREQ_MSB:`OCCS_P2S_FREQ_LSB];
  assign primary_synth_freq = primary_loop_config[`OCCS_PRI_FREQ_MSB:`OCCS_PRI_FREQ_LSB];
  assign secondary_synth_from_primary = primary_loop_config[`OCCS_FROM_PRIMARY_BIT];
  assign secondary_phase_measure = primary_loop_config[`OCCS_PHASE_MEASURE_BIT];

  always_comb begin
    if (secondary_synth_from_primary) begin
      next_secondary_khz = p2s_table(primary_to_secondary_freq);
    end else begin
      next_secondary_khz = secondary_table(secondary_synth_freq);
    end
  end

  assign next_primary_khz = primary_table(primary_synth_freq);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_secondary_synth_freq_khz <= `OCCS_KHZ_OFF;
      o_secondary_loop_freq_khz <= `OCCS_KHZ_OFF;
      o_primary_synth_freq_khz <= `OCCS_KHZ_OFF;
      o_primary_loop_freq_khz <= `OCCS_KHZ_OFF;
      secondary_loop_en <= 1'b0;
    end else begin
      o_secondary_synth_freq_khz <= next_secondary_khz;
      o_secondary_loop_freq_khz <= {next_secondary_khz[17:0], 2'b00};
      o_primary_synth_freq_khz <= next_primary_khz;
      o_primary_loop_freq_khz <= {next_primary_khz[17:0], 2'b00};
      secondary_loop_en <= (next_secondary_khz != `OCCS_KHZ_OFF);
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_secondary_synth_from_primary <= 1'b0;
      o_secondary_phase_measure <= 1'b0;
    end else begin
      o_secondary_synth_from_primary <= secondary_synth_from_primary;
      o_secondary_phase_measure <= secondary_phase_measure;
    end
  end

  assign o_secondary_loop_enable = secondary_loop_en;

  // Source pins cross into i_clock through two flops

  assign pin_raw = {i_primary_ref_div, i_secondary_ref_div, i_digital_rate_two,
                    i_digital_rate_one, i_second_primary_analog_loop,
                    i_secondary_analog_loop, i_primary_analog_loop};

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // Frame and multiframe waves; the multiframe wave toggles only on falling edges of the frame wave

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      frame_cnt <= 16'h0000;
      mframe_cnt <= 2'h0;
      wave_8k <= 1'b0;
      wave_2k <= 1'b0;
    end else if (frame_cnt == P_FRAME_HALF_CYCLES - 16'h0001) begin
      frame_cnt <= 16'h0000;
      wave_8k <= ~wave_8k;
      mframe_cnt <= (mframe_cnt == MFRAME_LAST) ? 2'h0 : mframe_cnt + 2'h1;
      if (mframe_cnt == MFRAME_LAST) begin
        wave_2k <= ~wave_2k;
      end
    end else begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end

  // Gates only move while the wave is low, so no sync pulse is cut
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mframe_gate <= 1'b0;
      frame_gate <= 1'b0;
    end else begin
      if (!wave_2k) begin
        mframe_gate <= output_select_seven_sync[`OCCS_MULTIFRAME_SYNC_PIN_GATE_BIT];
      end
      if (!wave_8k) begin
        frame_gate <= output_select_seven_sync[`OCCS_FRAME_SYNC_PIN_GATE_BIT];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_multiframe_sync_pin <= 1'b0;
      o_frame_sync_pin <= 1'b0;
    end else begin
      o_multiframe_sync_pin <= mframe_gate & wave_2k;
      o_frame_sync_pin <= frame_gate & wave_8k;
    end
  end

  // Source vector

  assign origin_clk = {pin_sync[2], pin_sync[1], pin_sync[0]};
  assign origin_en = {1'b1, secondary_loop_en, 1'b1};

  genvar g;
  generate
    for (g = 0; g < NUM_DIV; g++) begin : gen_div
      occs_divider #(
        .DIV(DIV_FACTOR[g])
      ) u_div (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_enable(origin_en[DIV_ORIGIN[g]]),
        .i_src(origin_clk[DIV_ORIGIN[g]]),
        .o_div(div_out[g])
      );
      assign src_vec[DIV_DEST[g]] = div_out[g];
    end
  endgenerate

  assign src_vec[OCCS_SRC_LOW] = 1'b0;
  assign src_vec[OCCS_SRC_2K] = wave_2k;
  assign src_vec[OCCS_SRC_8K] = wave_8k;
  assign src_vec[OCCS_SRC_DIG1] = pin_sync[3];
  assign src_vec[OCCS_SRC_DIG2] = pin_sync[4];
  assign src_vec[OCCS_SRC_P1] = pin_sync[0];
  assign src_vec[OCCS_SRC_S1] = pin_sync[1] & secondary_loop_en;
  assign src_vec[OCCS_SRC_Q1] = pin_sync[2];
  assign src_vec[OCCS_SRC_SREF] = pin_sync[5];
  assign src_vec[OCCS_SRC_PREF] = pin_sync[6];

  // Output selectors

  assign sel_code[0] = output_select_five_six[`OCCS_OUT5_SEL_MSB:`OCCS_OUT5_SEL_LSB];
  assign sel_code[1] = output_select_five_six[`OCCS_OUT6_SEL_MSB:`OCCS_OUT6_SEL_LSB];
  assign sel_code[2] = output_select_seven_sync[`OCCS_OUT7_SEL_MSB:`OCCS_OUT7_SEL_LSB];
  assign alt_bit = {i_out7_alt_decode, i_out6_alt_decode, i_out5_alt_decode};

  generate
    for (g = 0; g < 3; g++) begin : gen_out
      assign sel_src[g] = alt_bit[g] ? decode_alt(occs_out_t'(2'(g)), sel_code[g])
                                     : decode_std(occs_out_t'(2'(g)), sel_code[g]);
      occs_clean_switch u_switch (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_sources(src_vec),
        .i_select(sel_src[g]),
        .o_pin(pin_out[g])
      );
    end
  endgenerate

  assign o_out5_pin = pin_out[0];
  assign o_out6_pin = pin_out[1];
  assign o_out7_pin = pin_out[2];

endmodule : occs_output_select

`default_nettype wire

/* File: verilog/occs_defines.svh */
/*
  Register offsets, reset values, field positions, write masks,
  frequency table entries and timing figures for the output clock
  source select block. Assumes inclusion by bare name before use.
*/
`ifndef OCCS_DEFINES_SVH
`define OCCS_DEFINES_SVH

// Register offsets on the byte register port
`define OCCS_ADDR_OUT_SEL_56 8'h62
`define OCCS_ADDR_OUT_SEL_7_SYNC 8'h63
`define OCCS_ADDR_SEC_LOOP_CFG 8'h64
`define OCCS_ADDR_PRI_LOOP_CFG 8'h65

// Reset values
`define OCCS_RST_OUT_SEL_56 8'h84
`define OCCS_RST_OUT_SEL_7_SYNC 8'hc6
`define OCCS_RST_SEC_LOOP_CFG 8'h05
`define OCCS_RST_PRI_LOOP_CFG 8'h01

// Writable bits; the rest read as zero
`define OCCS_MASK_OUT_SEL_56 8'hff
`define OCCS_MASK_OUT_SEL_7_SYNC 8'hcf
`define OCCS_MASK_SEC_LOOP_CFG 8'h0f
`define OCCS_MASK_PRI_LOOP_CFG 8'hff

// Field positions
`define OCCS_OUT5_SEL_MSB 3
`define OCCS_OUT5_SEL_LSB 0
`define OCCS_OUT6_SEL_MSB 7
`define OCCS_OUT6_SEL_LSB 4
`define OCCS_OUT7_SEL_MSB 3
`define OCCS_OUT7_SEL_LSB 0
`define OCCS_MULTIFRAME_SYNC_PIN_GATE_BIT 7
`define OCCS_FRAME_SYNC_PIN_GATE_BIT 6
`define OCCS_SEC_FREQ_MSB 3
`define OCCS_SEC_FREQ_LSB 0
`define OCCS_PHASE_MEASURE_BIT 7
`define OCCS_FROM_PRIMARY_BIT 6
`define OCCS_P2S_FREQ_MSB 5
`define OCCS_P2S_FREQ_LSB 3
`define OCCS_PRI_FREQ_MSB 2
`define OCCS_PRI_FREQ_LSB 0

// Synthesis frequencies in kHz
`define OCCS_KHZ_OFF 20'h00000
`define OCCS_KHZ_77M760 20'h12fc0
`define OCCS_KHZ_24M576 20'h06000
`define OCCS_KHZ_32M768 20'h08000
`define OCCS_KHZ_37M056 20'h090c0
`define OCCS_KHZ_24M704 20'h06080
`define OCCS_KHZ_68M736 20'h10c80
`define OCCS_KHZ_44M736 20'h0aec0
`define OCCS_KHZ_25M248 20'h062a0
`define OCCS_KHZ_62M500 20'h0f424
`define OCCS_KHZ_30M720 20'h07800
`define OCCS_KHZ_40M000 20'h09c40
`define OCCS_KHZ_26M000 20'h06590

// Timing
`define OCCS_CLOCK_HZ 100000000
`define OCCS_FRAME_SYNC_HZ 8000
`define OCCS_MFRAME_SYNC_HZ 2000

`endif

/* File: verilog/occs_pkg.sv */
/*
  Types shared by the output clock source select design: the set of
  clock sources a pin may carry, the output identity and the states of
  the clean source switch. Assumes no other package.
*/
`default_nettype none

package occs_pkg;

  typedef enum logic [4:0] {
    OCCS_SRC_LOW, OCCS_SRC_2K, OCCS_SRC_8K, OCCS_SRC_DIG1, OCCS_SRC_DIG2,
    OCCS_SRC_P1, OCCS_SRC_P2, OCCS_SRC_P4, OCCS_SRC_P6, OCCS_SRC_P8,
    OCCS_SRC_P12, OCCS_SRC_P16, OCCS_SRC_P48,
    OCCS_SRC_S1, OCCS_SRC_S2, OCCS_SRC_S4, OCCS_SRC_S5, OCCS_SRC_S8,
    OCCS_SRC_S10, OCCS_SRC_S16, OCCS_SRC_S48, OCCS_SRC_S64,
    OCCS_SRC_Q1, OCCS_SRC_Q2, OCCS_SRC_Q5, OCCS_SRC_Q10,
    OCCS_SRC_SREF, OCCS_SRC_PREF
  } occs_src_t;

  localparam int unsigned OCCS_NUM_SRC = 28;

  typedef enum logic [1:0] {OCCS_OUT5, OCCS_OUT6, OCCS_OUT7} occs_out_t;

  typedef enum logic [1:0] {OCCS_SW_RUN, OCCS_SW_DRAIN, OCCS_SW_PARK} occs_sw_state_t;

endpackage : occs_pkg

`default_nettype wire

/* File: verilog/occs_divider.sv */
/*
  Integer clock divider working on a sampled source: counts rising
  edges of i_src and drives a registered wave of period DIV edges.
  Assumes i_src is already synchronised to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none

module occs_divider #(
  parameter int unsigned DIV = 2
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_enable,
  input wire logic i_src,
  output logic o_div
);

  localparam logic [6:0] LAST = 7'(DIV - 1);
  localparam logic [6:0] HALF = 7'(DIV / 2);

  logic src_prev;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic rise;

  assign rise = i_src & ~src_prev;
  assign next_cnt = (cnt == LAST) ? 7'h00 : cnt + 7'h01;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= i_src;
    end
  end

  // Odd divisors give a short high phase; duty is not balanced
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 7'h00;
      o_div <= 1'b0;
    end else if (!i_enable) begin
      cnt <= 7'h00;
      o_div <= 1'b0;
    end else if (rise) begin
      cnt <= next_cnt;
      o_div <= (next_cnt < HALF);
    end
  end

endmodule : occs_divider

`default_nettype wire

/* File: verilog/occs_clean_switch.sv */
/*
  Runt-free source switch for one output pin. On a new selection it
  lets the present source finish its high phase, parks the pin low and
  releases it only while the new source is low. Assumes all sources are
  levels on i_clock.
*/
`timescale 1ns/1ps
`default_nettype none

module occs_clean_switch
  import occs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [OCCS_NUM_SRC-1:0] i_sources,
  input wire occs_src_t i_select,
  output logic o_pin
);

  occs_sw_state_t state;
  occs_src_t cur;
  logic cur_level;

  assign cur_level = i_sources[cur];

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= OCCS_SW_RUN;
    end else begin
      unique case (state)
        OCCS_SW_RUN: if (i_select != cur) state <= OCCS_SW_DRAIN;
        OCCS_SW_DRAIN: if (!cur_level) state <= OCCS_SW_PARK;
        OCCS_SW_PARK: if (!i_sources[i_select]) state <= OCCS_SW_RUN;
      endcase
    end
  end

  // Selection tracked while parked so a late rewrite still lands cleanly
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= OCCS_SRC_LOW;
    end else if (state == OCCS_SW_PARK) begin
      cur <= i_select;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pin <= 1'b0;
    end else begin
      unique case (state)
        OCCS_SW_RUN: o_pin <= cur_level;
        OCCS_SW_DRAIN: o_pin <= cur_level;
        OCCS_SW_PARK: o_pin <= 1'b0;
      endcase
    end
  end

endmodule : occs_clean_switch

`default_nettype wire

/* File: sim/occs_properties.sv */
/*
  Checker bound into occs_output_select; sees its ports only.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module occs_properties (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wr_data,
  input wire logic o_out6_pin,
  input wire logic [19:0] o_primary_synth_freq_khz,
  input wire logic [19:0] o_primary_loop_freq_khz,
  input wire logic [19:0] o_secondary_synth_freq_khz,
  input wire logic [19:0] o_secondary_loop_freq_khz,
  input wire logic o_secondary_loop_enable,
  input wire logic o_secondary_synth_from_primary,
  input wire logic o_secondary_phase_measure
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire logic w64 = i_reg_wr_en && i_reg_addr == 8'h64;
  wire logic w65 = i_reg_wr_en && i_reg_addr == 8'h65;

  a_pri_freq: assert property (
    w65 && i_reg_wr_data[2:0] == 3'h7 |-> ##2 o_primary_synth_freq_khz == 20'h0f424)
    else $error("primary freq");
  a_pri_loop: assert property (
    o_primary_loop_freq_khz == {o_primary_synth_freq_khz[17:0], 2'b00}) else $error("pri loop");
  a_sec_loop: assert property (
    o_secondary_loop_freq_khz == {o_secondary_synth_freq_khz[17:0], 2'b00}) else $error("sec loop");
  a_sec_enable: assert property (
    o_secondary_loop_enable == (o_secondary_synth_freq_khz != 20'h0)) else $error("enable");
  a_sec_off: assert property (
    w64 && i_reg_wr_data[3:0] == 4'h0 && !o_secondary_synth_from_primary
    |-> ##2 !o_secondary_loop_enable) else $error("sec not off");
  a_follow_pri: assert property (
    w65 && i_reg_wr_data[6:3] == 4'h9 |-> ##2 o_secondary_synth_from_primary
    && o_secondary_synth_freq_khz == 20'h0f424) else $error("follow primary");
  a_free_run: assert property (
    w65 && i_reg_wr_data[7] |-> ##2 o_secondary_phase_measure) else $error("free run");
  a_no_runt: assert property (
    $rose(o_out6_pin) |=> o_out6_pin) else $error("runt pulse");
endmodule : occs_properties

bind occs_output_select occs_properties chk_i (.*);

`default_nettype wire

/* File: sim/occs_src_model.sv */
/*
  Far side: seven free-running source clocks of distinct rates.
  Assumes 1 ns units; every level outlasts two 10 ns cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module occs_src_model (
  output var logic [6:0] o_src
);
  // Distinct rates so a wrong source shows in edge counts
  for (genvar k = 0; k < 7; k++) begin : g_src
    initial o_src[k] = 1'b0;
    always #(23 + 10 * k) o_src[k] = ~o_src[k];
  end
endmodule : occs_src_model

`default_nettype wire

/* File: sim/occs_output_select_tb.sv */
/*
  Bench for occs_output_select: registers, frequencies, pin routing.
  Assumes occs_src_model drives the source clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module occs_output_select_tb;
  localparam int W = 1600;
  logic i_clock = 0, i_nrst = 0, i_reg_wr_en = 0, i_reg_rd_en = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wr_data = 8'h00, o_reg_rd_data, r = 8'h11;
  logic i_out5_alt_decode = 0, i_out6_alt_decode = 0, i_out7_alt_decode = 0;
  logic o_out5_pin, o_out6_pin, o_out7_pin, o_multiframe_sync_pin, o_frame_sync_pin;
  logic [19:0] o_primary_synth_freq_khz, o_primary_loop_freq_khz;
  logic [19:0] o_secondary_synth_freq_khz, o_secondary_loop_freq_khz;
  logic o_secondary_loop_enable, o_secondary_synth_from_primary, o_secondary_phase_measure;
  logic [6:0] s;
  logic [11:0] prv;
  int err_count = 0, samples_checked = 0, e, na, nb;
  int mdl[4] = '{8'h84, 8'hc6, 8'h05, 8'h01};
  int msk[4] = '{8'hff, 8'hcf, 8'h0f, 8'hff};
  int stb[16] = '{0, 77760, 24576, 32768, 37056, 24704, 68736, 44736,
    25248, 62500, 30720, 40000, 26000, 0, 0, 0};
  int p2s[8] = '{24576, 62500, 32768, 0, 37056, 0, 24704, 25248};
  int ptb[8] = '{77760, 77760, 24576, 32768, 37056, 24704, 25248, 62500};
  wire [11:0] obs = {o_out7_pin, o_out6_pin, o_out5_pin, o_multiframe_sync_pin,
    o_frame_sync_pin, s};

  always #5 i_clock = ~i_clock;
  always @(negedge i_clock) prv <= obs;
  occs_src_model far (.o_src(s));
  occs_output_select #(.P_FRAME_HALF_CYCLES(16'h0008)) uut (.*,
    .i_primary_analog_loop(s[0]), .i_secondary_analog_loop(s[1]),
    .i_second_primary_analog_loop(s[2]), .i_digital_rate_one(s[3]),
    .i_digital_rate_two(s[4]), .i_secondary_ref_div(s[5]), .i_primary_ref_div(s[6]));

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic ck(input string n, input logic [19:0] x, input logic [19:0] g, input int t);
    samples_checked++;
    if (g !== x && (t == 0 || g > x + t || g + t < x)) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", n, x, g);
    end
  endtask : ck

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wr_data = d;
    i_reg_wr_en = 1;
    @(negedge i_clock) i_reg_wr_en = 0;
    if (a inside {[8'h62:8'h65]}) mdl[a - 8'h62] = d & msk[a - 8'h62];
    @(negedge i_clock);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_reg_addr = a;
    i_reg_rd_en = 1;
    @(negedge i_clock) i_reg_rd_en = 0;
    @(negedge i_clock);
    ck("read", a inside {[8'h62:8'h65]} ? 20'(mdl[a - 8'h62]) : 20'h0, 20'(o_reg_rd_data), 0);
  endtask : rd

  // Settling first: a switch may wait out a long high phase of the old source
  task automatic cnt(input int x, input int y, output int nx, output int ny);
    nx = 0;
    ny = 0;
    repeat (400) @(negedge i_clock);
    repeat (W) begin
      @(negedge i_clock);
      nx += obs[x] & ~prv[x];
      ny += obs[y] & ~prv[y];
    end
  endtask : cnt

  // Only the measured output gets the asked decode; the others the opposite
  task automatic chk(input int o, input bit al, input int c, input int i, input int dv);
    {i_out7_alt_decode, i_out6_alt_decode, i_out5_alt_decode} = al ? 3'(1 << o) : ~3'(1 << o);
    wr(8'h62, {4'(c), 4'(c)});
    wr(8'h63, {4'hc, 4'(c)});
    cnt(9 + o, i, na, nb);
    ck("pin edges", 20'(dv ? nb / dv : 0), 20'(na), 1);
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #800us;
    err_count++;
    results();
  end

  initial begin
    repeat (6) @(negedge i_clock);
    i_nrst = 1;
    for (int k = 0; k < 5; k++) begin
      rd(8'(8'h62 + k));
    end
    wr(8'h63, 8'hff);
    rd(8'h63);
    chk(1, 0, 2, 7, 1);
    chk(1, 0, 3, 0, 2);
    chk(0, 0, 6, 0, 16);
    chk(2, 0, 12, 1, 48);
    chk(0, 0, 3, 4, 1);
    chk(0, 0, 11, 1, 2);
    chk(2, 0, 4, 0, 2);
    chk(2, 0, 11, 1, 64);
    chk(1, 1, 1, 1, 5);
    chk(1, 1, 6, 2, 1);
    chk(2, 1, 9, 0, 0);
    chk(0, 1, 3, 1, 10);
    chk(0, 1, 4, 2, 10);
    chk(0, 1, 7, 5, 1);
    chk(2, 1, 8, 6, 1);
    chk(1, 0, 1, 8, 1);
    chk(1, 0, 4, 3, 1);
    chk(1, 0, 5, 0, 1);
    chk(2, 0, 5, 0, 48);
    chk(0, 0, 7, 0, 12);
    chk(1, 0, 8, 0, 8);
    chk(2, 0, 9, 0, 6);
    chk(0, 0, 10, 0, 4);
    chk(1, 0, 13, 1, 16);
    chk(2, 0, 14, 1, 8);
    chk(0, 0, 15, 1, 4);
    chk(0, 1, 2, 0, 1);
    chk(2, 1, 5, 2, 2);
    chk(1, 1, 3, 1, 1);
    chk(1, 0, 0, 0, 0);
    wr(8'h63, 8'h40);
    cnt(8, 7, na, nb);
    ck("mframe edges", 20'h0, 20'(na), 1);
    ck("frame edges", 20'(W / 16), 20'(nb), 1);
    wr(8'h63, 8'h80);
    cnt(8, 7, na, nb);
    ck("mframe edges", 20'(W / 64), 20'(na), 1);
    ck("frame edges", 20'h0, 20'(nb), 1);
    for (int i = 0; i < 32; i++) begin
      r = lfsr(r);
      wr(8'h64, {r[7:4], 4'(i)});
      wr(8'h65, {r[7], i[4], i[2:0], ~i[2:0]});
      e = mdl[3][6] ? p2s[mdl[3][5:3]] : stb[mdl[2][3:0]];
      ck("pri synth", 20'(ptb[mdl[3][2:0]]), o_primary_synth_freq_khz, 0);
      ck("pri loop", 20'(4 * ptb[mdl[3][2:0]]), o_primary_loop_freq_khz, 0);
      ck("sec synth", 20'(e), o_secondary_synth_freq_khz, 0);
      ck("sec loop", 20'(4 * e), o_secondary_loop_freq_khz, 0);
      ck("sec enable", 20'(e != 0), 20'(o_secondary_loop_enable), 0);
      ck("from pri", 20'(mdl[3][6]), 20'(o_secondary_synth_from_primary), 0);
      ck("measure", 20'(mdl[3][7]), 20'(o_secondary_phase_measure), 0);
      rd(8'h64);
    end
    results();
  end
endmodule : occs_output_select_tb

`default_nettype wire
